// file: verilog/rrs_defs.svh
`ifndef RRS_DEFS_SVH
`define RRS_DEFS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RRS_ADDR_CFG_A 8'h40
`define RRS_ADDR_OOF_LO 8'h43
`define RRS_ADDR_OOF_HI 8'h44
`define RRS_ADDR_B1_LO 8'h45
`define RRS_ADDR_B1_HI 8'h46
`define RRS_ADDR_CFG_B 8'h47
`define RRS_ADDR_STATUS 8'h48
`define RRS_ADDR_MASK 8'h49
`define RRS_ADDR_VERSION 8'h52
`define RRS_ADDR_SNAP_ALL 8'h54
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RRS_A_CLK_LOS 7
`define RRS_A_AIS_LOF 6
`define RRS_A_AIS_LOS 5
`define RRS_A_AIS_FRC 4
`define RRS_A_AIS_TIM 3
`define RRS_A_LOS_HI 2
`define RRS_A_LOS_LO 1
`define RRS_A_ACQ 0
`define RRS_B_B1_MODE 0
`define RRS_ST_LOS 0
`define RRS_ST_SYNC_LOST 1
`define RRS_ST_SYNC_GAIN 2
`define RRS_ST_AIS 3
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RRS_CFG_A_RST 8'h80
`define RRS_CFG_B_RST 8'h00
`define RRS_VERSION_DEF 8'hA5
// ----------------------------------------------------------------------
// Timing counts, in line clocks or frames
// ----------------------------------------------------------------------
`define RRS_LOS_WEAK_SER 13'h0080
`define RRS_LOS_WEAK_PAR 13'h0010
`define RRS_LOS_STRONG_SER 13'h1000
`define RRS_LOS_STRONG_PAR 13'h0200
`define RRS_ACQ_NORM_FRAMES 3'h2
`define RRS_ACQ_ROB_NDF 3'h5
`define RRS_ACQ_ROB_FW 3'h2
`define RRS_LOSE_FW 4'h4
`define RRS_LOSE_NDF 4'h8
`endif

// file: verilog/rrs_pkg.sv
package rrs_pkg;
   typedef enum logic [0:0] {
      RRS_SEARCH = 1'b0,
      RRS_SYNC = 1'b1
   } rrs_frm_state_t;
endpackage

// file: verilog/rrs_los_filter.sv
`timescale 1ns/1ps
`include "rrs_defs.svh"
module rrs_los_filter (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic line_clk_en,
   input wire logic los_raw,
   input wire logic [1:0] filter_sel,
   input wire logic serial_sel,
   output logic los_alarm
);
   logic [12:0] cnt_q;
   logic [12:0] thr;
   logic alarm_d;

   // -------------------------------------------------------------------
   // Persistence counter
   // -------------------------------------------------------------------
   always_comb begin
      if (filter_sel[0]) begin
         thr = serial_sel ? `RRS_LOS_STRONG_SER : `RRS_LOS_STRONG_PAR;
      end else begin
         thr = serial_sel ? `RRS_LOS_WEAK_SER : `RRS_LOS_WEAK_PAR;
      end
   end

   // Saturates at the threshold so a long outage never wraps
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 13'h0000;
      end else if (!los_raw) begin
         cnt_q <= 13'h0000;
      end else if (line_clk_en && cnt_q < thr) begin
         cnt_q <= cnt_q + 13'h0001;
      end
   end

   // Alarm drops as soon as the raw condition clears
   assign alarm_d = los_raw && (!filter_sel[1] || cnt_q >= thr);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         los_alarm <= 1'b0;
      end else begin
         los_alarm <= alarm_d;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   no_filter_a: assert property (
      !filter_sel[1] |=> los_alarm == $past(los_raw))
      else $error("unfiltered alarm does not follow raw loss");
   weak_ser_a: assert property (
      $rose(los_alarm) && $past(filter_sel) == 2'b10 && $past(serial_sel)
      |-> $past(cnt_q) == 13'h0080)
      else $error("weak serial alarm before 128 clocks");
   strong_par_a: assert property (
      $rose(los_alarm) && $past(filter_sel) == 2'b11 && !$past(serial_sel)
      |-> $past(cnt_q) == 13'h0200)
      else $error("strong parallel alarm before 512 clocks");
endmodule // rrs_los_filter

// file: verilog/rrs_config.sv
`timescale 1ns/1ps
`include "rrs_defs.svh"
// Notes on behaviour
// - Version register is 8-bit read-only; writes are ignored.
// - Write to snapshot-all location buffers every counter then clears it.
// - Counter addresses return the buffered snapshot, not the live count.
// - Write to a counter's high byte snapshots and clears only that one.
// - Backup clock selected during loss of signal when enabled (default).
// - Frame-loss enable sends AIS downstream while frame loss is active.
// - Signal-loss enable sends AIS downstream while signal loss is active.
// - Force bit sends AIS downstream unconditionally.
// - Trace-mismatch enable sends AIS while mismatch state is active.
// - Filter field with upper bit zero means alarm follows raw loss.
// - Weak filter needs 128 serial or 16 parallel clocks of loss.
// - Strong filter needs 4096 serial or 512 parallel clocks of loss.
// - Acquisition mode bit matters only in STM-0; STM-1 uses normal.
// - Normal: sync after two frames with good word and same NDF.
// - Sync lost after four consecutive bad framing words in any mode.
// - Robust: five frames same NDF plus two good words to sync.
// - Robust: sync also lost after eight frames with differing NDF.
// - Parity counter counts bit errors in mode 0, blocks in mode 1.
module rrs_config #(
   parameter logic [7:0] VERSION = `RRS_VERSION_DEF // Arbitrary value
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   input wire logic line_clk_en,
   input wire logic los_raw,
   input wire logic line_interface_format_sel,
   input wire logic stm0_mode,
   input wire logic lof_state,
   input wire logic section_trace_mismatch_state,
   input wire logic frame_tick,
   input wire logic frame_word_ok,
   input wire logic [3:0] ndf_bits,
   input wire logic parity_check,
   input wire logic [3:0] parity_err_bits,
   input wire logic oof_event,
   output logic los_alarm,
   output logic backup_clock_sel,
   output logic ais_to_mux,
   output rrs_pkg::rrs_frm_state_t frame_state
);
   import rrs_pkg::*;

   logic [7:0] cfg_a_q;
   logic cfg_b_q;
   logic [3:0] status_q;
   logic [3:0] mask_q;
   logic [15:0] b1_cnt_q;
   logic [15:0] b1_buf_q;
   logic [12:0] oof_cnt_q;
   logic [12:0] oof_buf_q;
   logic [3:0] ndf_prev_q;
   logic [2:0] both_q;
   logic [2:0] ndf_same_q;
   logic [2:0] fw_good_q;
   logic [3:0] fw_bad_q;
   logic [3:0] ndf_diff_q;
   logic los_prev_q;
   logic ais_prev_q;
   logic [7:0] rd_mux;
   logic snap_all;
   logic snap_b1;
   logic snap_oof;
   logic [15:0] b1_inc;
   logic [15:0] oof_sum;
   logic robust;
   logic same_ndf;
   logic sync_gain;
   logic sync_lose;
   logic [3:0] events;

   function automatic logic [15:0] sat_add(input logic [15:0] v,
                                           input logic [15:0] inc,
                                           input logic [15:0] max);
      logic [16:0] s;
      s = {1'b0, v} + {1'b0, inc};
      if (s > {1'b0, max}) begin
         sat_add = max;
      end else begin
         sat_add = s[15:0];
      end
   endfunction

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_a_q <= `RRS_CFG_A_RST;
      end else if (reg_wr && reg_addr == `RRS_ADDR_CFG_A) begin
         cfg_a_q <= reg_wdata;
      end
   end

   // Only the mode bit is stored
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_b_q <= 1'(`RRS_CFG_B_RST >> `RRS_B_B1_MODE);
      end else if (reg_wr && reg_addr == `RRS_ADDR_CFG_B) begin
         cfg_b_q <= reg_wdata[`RRS_B_B1_MODE];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= 4'h0;
      end else if (reg_wr && reg_addr == `RRS_ADDR_MASK) begin
         mask_q <= reg_wdata[3:0];
      end
   end

   // -------------------------------------------------------------------
   // Loss of signal filter and alarm outputs
   // -------------------------------------------------------------------
   rrs_los_filter u_los (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .line_clk_en(line_clk_en),
      .los_raw(los_raw),
      .filter_sel(cfg_a_q[`RRS_A_LOS_HI:`RRS_A_LOS_LO]),
      .serial_sel(line_interface_format_sel),
      .los_alarm(los_alarm)
   );

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         backup_clock_sel <= 1'b0;
      end else begin
         backup_clock_sel <= cfg_a_q[`RRS_A_CLK_LOS] && los_alarm;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ais_to_mux <= 1'b0;
      end else begin
         ais_to_mux <= cfg_a_q[`RRS_A_AIS_FRC]
            || (cfg_a_q[`RRS_A_AIS_LOF] && lof_state)
            || (cfg_a_q[`RRS_A_AIS_LOS] && los_alarm)
            || (cfg_a_q[`RRS_A_AIS_TIM]
                && section_trace_mismatch_state);
      end
   end

   // -------------------------------------------------------------------
   // Frame acquisition
   // -------------------------------------------------------------------
   assign robust = stm0_mode && cfg_a_q[`RRS_A_ACQ];
   assign same_ndf = ndf_bits == ndf_prev_q;

   always_comb begin
      sync_gain = 1'b0;
      sync_lose = 1'b0;
      if (frame_tick && frame_state == RRS_SEARCH) begin
         if (robust) begin
            sync_gain = frame_word_ok && fw_good_q >= `RRS_ACQ_ROB_FW - 3'h1
               && same_ndf
               && ndf_same_q >= `RRS_ACQ_ROB_NDF - 3'h1;
         end else begin
            sync_gain = frame_word_ok && same_ndf
               && both_q == `RRS_ACQ_NORM_FRAMES - 3'h1;
         end
      end
      if (frame_tick && frame_state == RRS_SYNC) begin
         sync_lose = (!frame_word_ok
                      && fw_bad_q == `RRS_LOSE_FW - 4'h1)
            || (robust && !same_ndf
                && ndf_diff_q == `RRS_LOSE_NDF - 4'h1);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         frame_state <= RRS_SEARCH;
      end else if (sync_gain) begin
         frame_state <= RRS_SYNC;
      end else if (sync_lose) begin
         frame_state <= RRS_SEARCH;
      end
   end

   // Run lengths restart at every change of state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ndf_prev_q <= 4'h0;
         both_q <= 3'h0;
         ndf_same_q <= 3'h0;
         fw_good_q <= 3'h0;
         fw_bad_q <= 4'h0;
         ndf_diff_q <= 4'h0;
      end else if (frame_tick) begin
         ndf_prev_q <= ndf_bits;
         if (sync_gain || sync_lose) begin
            both_q <= 3'h0;
            ndf_same_q <= 3'h0;
            fw_good_q <= 3'h0;
            fw_bad_q <= 4'h0;
            ndf_diff_q <= 4'h0;
         end else begin
            both_q <= (frame_word_ok && same_ndf && both_q < 3'h7)
               ? both_q + 3'h1 : 3'h0;
            // Saturate so a long run never wraps back below the threshold
            ndf_same_q <= same_ndf
               ? ndf_same_q + {2'h0, ndf_same_q != 3'h7} : 3'h0;
            fw_good_q <= frame_word_ok
               ? fw_good_q + {2'h0, fw_good_q != 3'h7} : 3'h0;
            fw_bad_q <= (!frame_word_ok && fw_bad_q < 4'hF)
               ? fw_bad_q + 4'h1 : 4'h0;
            ndf_diff_q <= (!same_ndf && ndf_diff_q < 4'hF)
               ? ndf_diff_q + 4'h1 : 4'h0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Performance counters and snapshot buffers
   // -------------------------------------------------------------------
   assign snap_all = reg_wr && reg_addr == `RRS_ADDR_SNAP_ALL;
   assign snap_b1 = snap_all
      || (reg_wr && reg_addr == `RRS_ADDR_B1_HI);
   assign snap_oof = snap_all
      || (reg_wr && reg_addr == `RRS_ADDR_OOF_HI);
   assign oof_sum = sat_add({3'h0, oof_cnt_q}, {15'h0000, oof_event},
                            16'h1FFF);

   always_comb begin
      b1_inc = 16'h0000;
      if (parity_check) begin
         if (cfg_b_q) begin
            b1_inc = {15'h0000, parity_err_bits != 4'h0};
         end else begin
            b1_inc = {12'h000, parity_err_bits};
         end
      end
   end

   // An error in the snapshot cycle lands in the fresh count, not lost
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         b1_cnt_q <= 16'h0000;
         b1_buf_q <= 16'h0000;
      end else if (snap_b1) begin
         b1_buf_q <= b1_cnt_q;
         b1_cnt_q <= b1_inc;
      end else begin
         b1_cnt_q <= sat_add(b1_cnt_q, b1_inc, 16'hFFFF);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         oof_cnt_q <= 13'h0000;
         oof_buf_q <= 13'h0000;
      end else if (snap_oof) begin
         oof_buf_q <= oof_cnt_q;
         oof_cnt_q <= {12'h000, oof_event};
      end else begin
         oof_cnt_q <= oof_sum[12:0];
      end
   end

   // -------------------------------------------------------------------
   // Interrupt status
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         los_prev_q <= 1'b0;
         ais_prev_q <= 1'b0;
      end else begin
         los_prev_q <= los_alarm;
         ais_prev_q <= ais_to_mux;
      end
   end

   always_comb begin
      events = 4'h0;
      events[`RRS_ST_LOS] = los_alarm && !los_prev_q;
      events[`RRS_ST_SYNC_LOST] = sync_lose;
      events[`RRS_ST_SYNC_GAIN] = sync_gain;
      events[`RRS_ST_AIS] = ais_to_mux && !ais_prev_q;
   end

   // Set wins over the clearing read so no event slips through
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= 4'h0;
      end else if (reg_rd && reg_addr == `RRS_ADDR_STATUS) begin
         status_q <= events;
      end else begin
         status_q <= status_q | events;
      end
   end

   assign irq = |(status_q & mask_q);

   // -------------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------------
   always_comb begin
      unique case (reg_addr)
         `RRS_ADDR_CFG_A: rd_mux = cfg_a_q;
         `RRS_ADDR_OOF_LO: rd_mux = oof_buf_q[7:0];
         `RRS_ADDR_OOF_HI: rd_mux = {3'h0, oof_buf_q[12:8]};
         `RRS_ADDR_B1_LO: rd_mux = b1_buf_q[7:0];
         `RRS_ADDR_B1_HI: rd_mux = b1_buf_q[15:8];
         `RRS_ADDR_CFG_B: rd_mux = {7'h00, cfg_b_q};
         `RRS_ADDR_STATUS: rd_mux = {4'h0, status_q};
         `RRS_ADDR_MASK: rd_mux = {4'h0, mask_q};
         `RRS_ADDR_VERSION: rd_mux = VERSION;
         default: rd_mux = 8'h00;
      endcase
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   version_read_a: assert property (
      reg_rd && reg_addr == `RRS_ADDR_VERSION |=> reg_rdata == VERSION)
      else $error("version register read wrong");
   snap_copy_a: assert property (
      snap_all |=> b1_buf_q == $past(b1_cnt_q)
         && oof_buf_q == $past(oof_cnt_q))
      else $error("snapshot did not copy counters");
   snap_clear_a: assert property (
      snap_all && !parity_check && !oof_event
      |=> b1_cnt_q == 16'h0000 && oof_cnt_q == 13'h0000)
      else $error("snapshot did not clear counters");
   buf_read_a: assert property (
      reg_rd && reg_addr == `RRS_ADDR_B1_HI
      |=> reg_rdata == b1_buf_q[15:8])
      else $error("counter read not from buffer");
   single_snap_a: assert property (
      reg_wr && reg_addr == `RRS_ADDR_B1_HI
      |=> $stable(oof_buf_q) && b1_buf_q == $past(b1_cnt_q))
      else $error("single snapshot touched wrong counter");
   backup_clock_a: assert property (
      los_alarm && cfg_a_q[`RRS_A_CLK_LOS] |=> backup_clock_sel)
      else $error("backup clock not selected on loss");
   ais_frame_a: assert property (
      lof_state && cfg_a_q[`RRS_A_AIS_LOF] |=> ais_to_mux)
      else $error("no AIS on frame loss");
   ais_signal_a: assert property (
      los_alarm && cfg_a_q[`RRS_A_AIS_LOS] |=> ais_to_mux)
      else $error("no AIS on signal loss");
   ais_force_a: assert property (
      cfg_a_q[`RRS_A_AIS_FRC] [*2] |-> ais_to_mux)
      else $error("forced AIS missing");
   ais_trace_a: assert property (
      section_trace_mismatch_state && cfg_a_q[`RRS_A_AIS_TIM]
      |=> ais_to_mux)
      else $error("no AIS on trace mismatch");
   normal_sync_a: assert property (
      frame_tick && !robust && frame_state == RRS_SEARCH && frame_word_ok
      && same_ndf && both_q == 3'h1 |=> frame_state == RRS_SYNC)
      else $error("normal acquisition did not sync");
   fw_lose_a: assert property (
      frame_tick && frame_state == RRS_SYNC && !frame_word_ok
      && fw_bad_q == 4'h3 |=> frame_state == RRS_SEARCH)
      else $error("sync kept after four bad words");
   robust_hold_a: assert property (
      frame_tick && robust && frame_state == RRS_SEARCH
      && ndf_same_q < 3'h4 |=> frame_state == RRS_SEARCH)
      else $error("robust sync too early");
   ndf_lose_a: assert property (
      frame_tick && robust && frame_state == RRS_SYNC && !same_ndf
      && ndf_diff_q == 4'h7 |=> frame_state == RRS_SEARCH)
      else $error("sync kept after eight NDF changes");
   block_count_a: assert property (
      parity_check && cfg_b_q && parity_err_bits != 4'h0 && !snap_b1
      && b1_cnt_q < 16'hFFFF |=> b1_cnt_q == $past(b1_cnt_q) + 16'h0001)
      else $error("block mode did not count one");
endmodule // rrs_config

// file: sim/rrs_line_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Received line stream: one frame per send request
// ------------------------------------------------------------
module rrs_line_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic send,
   input wire logic ok_in,
   input wire logic [3:0] ndf_in,
   input wire logic [3:0] err_in,
   output logic line_clk_en,
   output logic frame_tick,
   output logic frame_word_ok,
   output logic [3:0] ndf_bits,
   output logic [3:0] parity_err_bits,
   output logic parity_check
);
   // Frame fields invert between frames so stale values never look valid
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         line_clk_en <= 1'b0;
         frame_tick <= 1'b0;
         parity_check <= 1'b0;
         frame_word_ok <= 1'b0;
         ndf_bits <= 4'h0;
         parity_err_bits <= 4'h0;
      end else begin
         line_clk_en <= 1'b1;
         frame_tick <= send;
         parity_check <= send;
         frame_word_ok <= send ? ok_in : ~frame_word_ok;
         ndf_bits <= send ? ndf_in : ~ndf_bits;
         parity_err_bits <= send ? err_in : ~parity_err_bits;
      end
   end
endmodule // rrs_line_model

// file: sim/test_rrs_config.sv
`timescale 1ns/1ps
`include "rrs_defs.svh"
module test_rrs_config;
   import rrs_pkg::*;
   logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, irq;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d, h;
   logic line_clk_en, los_raw = 0, fmt = 0, stm0 = 0, lof = 0, tim = 0;
   logic oof = 0, frame_tick, frame_word_ok, parity_check;
   logic [3:0] ndf_bits, parity_err_bits, ndf_in = 0, err_in = 0;
   logic los_alarm, bck, ais, send = 0, ok_in = 0;
   rrs_frm_state_t frame_state;
   int fails = 0, checks_done = 0, cyc = 0;
   logic [31:0] seed = 32'h5D55FA92;
   logic [15:0] sum, e;
   rrs_config u_rrs_config (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .line_clk_en(line_clk_en), .los_raw(los_raw),
      .line_interface_format_sel(fmt), .stm0_mode(stm0),
      .lof_state(lof), .section_trace_mismatch_state(tim),
      .frame_tick(frame_tick), .frame_word_ok(frame_word_ok),
      .ndf_bits(ndf_bits), .parity_check(parity_check),
      .parity_err_bits(parity_err_bits), .oof_event(oof),
      .los_alarm(los_alarm), .backup_clock_sel(bck),
      .ais_to_mux(ais), .frame_state(frame_state));
   rrs_line_model u_rrs_line_model (.clk_sys(clk_sys), .rst_n(rst_n),
      .send(send), .ok_in(ok_in), .ndf_in(ndf_in), .err_in(err_in),
      .line_clk_en(line_clk_en), .frame_tick(frame_tick),
      .frame_word_ok(frame_word_ok), .ndf_bits(ndf_bits),
      .parity_err_bits(parity_err_bits), .parity_check(parity_check));
   // ------------------------------------------------------------
   // Bench helpers
   // ------------------------------------------------------------
   initial forever #2 clk_sys = ~clk_sys;
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic summarize();
      if (fails == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Ceiling covers the 4096-clock filter case with ample slack
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end
   task automatic chk(string n, logic [15:0] x, logic [15:0] g);
      checks_done++;
      if (x !== g) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic w(int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      v = reg_rdata;
   endtask
   task automatic frm(logic ok, logic [3:0] nd, logic [3:0] er);
      @(posedge clk_sys);
      send <= 1'b1;
      ok_in <= ok;
      ndf_in <= nd;
      err_in <= er;
      @(posedge clk_sys);
      send <= 1'b0;
   endtask
   // Alternating NDF starts at 1 so the first frame already differs
   task automatic frms(int n, logic ok, logic alt);
      for (int i = 0; i < n; i++) frm(ok, {3'h0, alt & ~i[0]}, 4'h0);
      w(3);
   endtask
   task automatic st(logic [15:0] x);
      chk("frame_state", x, 16'(frame_state));
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(`RRS_ADDR_CFG_A, d); chk("cfg_a", 16'h0080, d);
      rd(`RRS_ADDR_VERSION, d); chk("ver", `RRS_VERSION_DEF, d);
      wr(`RRS_ADDR_VERSION, seed[7:0]);
      rd(`RRS_ADDR_VERSION, d); chk("ver", `RRS_VERSION_DEF, d);
      rd(8'h7F, d); chk("unmapped", 16'h0000, d);
      wr(`RRS_ADDR_CFG_B, 8'hFF);
      rd(`RRS_ADDR_CFG_B, d); chk("cfg_b", 16'h0001, d);
      wr(`RRS_ADDR_CFG_B, 8'h00);
      wr(`RRS_ADDR_CFG_A, 8'hA0);
      @(posedge clk_sys) los_raw <= 1'b1;
      w(1); chk("los_alarm", 16'h0001, los_alarm);
      w(2); chk("backup", 16'h0001, bck);
      chk("ais", 16'h0001, ais);
      @(posedge clk_sys) los_raw <= 1'b0;
      w(3); chk("backup", 16'h0000, bck);
      for (int i = 0; i < 4; i++) begin
         wr(`RRS_ADDR_CFG_A, 8'h00);
         @(posedge clk_sys) {lof, los_raw, tim} <= 3'h7;
         w(3); chk("ais", 16'h0000, ais);
         wr(`RRS_ADDR_CFG_A, 8'h40 >> i);
         w(3); chk("ais", 16'h0001, ais);
         @(posedge clk_sys) {lof, los_raw, tim} <= 3'h0;
         w(3); chk("ais", 16'(i == 2), ais);
      end
      for (int i = 0; i < 4; i++) begin
         e = (i > 1) ? (i[0] ? 4096 : 512) : (i[0] ? 128 : 16);
         @(posedge clk_sys) fmt <= i[0];
         wr(`RRS_ADDR_CFG_A, (i > 1) ? 8'h06 : 8'h04);
         @(posedge clk_sys) los_raw <= 1'b1;
         w(e); chk("los_alarm", 16'h0000, los_alarm);
         w(1); chk("los_alarm", 16'h0001, los_alarm);
         @(posedge clk_sys) los_raw <= 1'b0;
         w(3);
      end
      // STM-1 with the robust bit set must still acquire in two frames
      wr(`RRS_ADDR_CFG_A, 8'h01);
      rd(`RRS_ADDR_STATUS, d);
      frms(1, 1'b1, 1'b0); st(RRS_SEARCH);
      frms(1, 1'b1, 1'b0); st(RRS_SYNC);
      chk("irq", 16'h0000, irq);
      wr(`RRS_ADDR_MASK, 8'h04);
      w(2); chk("irq", 16'h0001, irq);
      rd(`RRS_ADDR_STATUS, d); chk("status", 16'h0004, d & 8'h04);
      w(2); chk("irq", 16'h0000, irq);
      frms(3, 1'b0, 1'b0); st(RRS_SYNC);
      frms(1, 1'b0, 1'b0); st(RRS_SEARCH);
      @(posedge clk_sys) stm0 <= 1'b1;
      frms(3, 1'b1, 1'b0); st(RRS_SEARCH);
      frms(2, 1'b1, 1'b0); st(RRS_SYNC);
      frms(7, 1'b1, 1'b1); st(RRS_SYNC);
      frms(1, 1'b1, 1'b0); st(RRS_SEARCH);
      // Bit-error counting with random error weights
      wr(`RRS_ADDR_SNAP_ALL, 8'h00);
      sum = 0;
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         sum += {13'h0, seed[2:0]} + 16'h1;
         frm(1'b1, 4'h0, {1'b0, seed[2:0]} + 4'h1);
      end
      @(posedge clk_sys) oof <= 1'b1;
      @(posedge clk_sys) oof <= 1'b0;
      w(2);
      wr(`RRS_ADDR_SNAP_ALL, 8'h5A);
      rd(`RRS_ADDR_B1_LO, d); rd(`RRS_ADDR_B1_HI, h);
      chk("b1_buf", sum, {h, d});
      rd(`RRS_ADDR_OOF_LO, d); chk("oof_buf", 16'h0001, d);
      @(posedge clk_sys) oof <= 1'b1;
      repeat (2) @(posedge clk_sys);
      oof <= 1'b0;
      frm(1'b1, 4'h0, 4'h6);
      w(2);
      rd(`RRS_ADDR_B1_LO, d); chk("b1_buf", sum, {8'h0, d});
      wr(`RRS_ADDR_B1_HI, 8'h00);
      rd(`RRS_ADDR_B1_LO, d); chk("b1_buf", 16'h0006, d);
      rd(`RRS_ADDR_OOF_LO, d); chk("oof_buf", 16'h0001, d);
      wr(`RRS_ADDR_SNAP_ALL, 8'h00);
      rd(`RRS_ADDR_OOF_LO, d); chk("oof_buf", 16'h0002, d);
      wr(`RRS_ADDR_CFG_B, 8'h01);
      frm(1'b1, 4'h0, 4'h3);
      frm(1'b1, 4'h0, 4'h0);
      frm(1'b1, 4'h0, 4'h8);
      w(2);
      wr(`RRS_ADDR_B1_HI, 8'h00);
      rd(`RRS_ADDR_B1_LO, d); chk("b1_blocks", 16'h0002, d);
      summarize();
   end
endmodule // test_rrs_config
